// [rtl/tsc_pkg.sv]
package tsc_pkg;

    localparam int SMP_W  = 16;
    localparam int ADDR_W = 17;
    localparam int CNT_W  = 18;
    localparam int SEL_W  = 3;
    localparam int BYTE_W = 8;
    localparam int PIN_W  = 6 + SMP_W;

    // Block length is 2**(LEN_BASE_LOG + select): 1k up to 128k words
    localparam logic [4:0]       LEN_BASE_LOG = 5'hA;
    localparam logic [CNT_W-1:0] CNT_ONE      = 18'h00001;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 18'h00000;

    typedef enum {
        ST_IDLE,
        ST_ARMED,
        ST_CAPTURE,
        ST_DONE,
        ST_XFER_RD,
        ST_XFER_WAIT,
        ST_XFER_LO,
        ST_XFER_HI
    } tsc_state_type;

    typedef struct packed {
        logic transfer;
        logic id_mem;
        logic reset;
        logic power;
        logic overflow;
        logic done;
        logic armed;
        logic triggered;
    } tsc_led_type;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [SMP_W-1:0]  data;
    } tsc_mem_type;

    localparam tsc_led_type LED_RESET = 8'h20;
    localparam tsc_mem_type MEM_IDLE  = 34'h000000000;

endpackage : tsc_pkg

// [rtl/tsc_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module tsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] din_in,
    output logic      [W-1:0] dout_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= din_in;
            sync_ff <= meta_ff;
        end
    end

    assign dout_out = sync_ff;

endmodule : tsc_sync

`default_nettype wire

// [rtl/tsc_capture.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// - One contiguous block per acquisition, length selectable up to 128k.
// - Trigger is internal or external, chosen by a configuration input.
// - External trigger starts capture only on its selected edge polarity.
// - Armed indicator lit while waiting for a trigger.
// - Triggered indicator lit once trigger accepted and collection runs.
// - Done indicator lit when the requested count of samples is stored.
// - Overflow indicator set by overrange during capture, for latest block.
// - Reset indicator lit during hard reset or soft reset.
// - Transfer indicator lit while stored samples move to the host.
// - Id memory indicator lit while that memory is present or accessed.
// - Eight status indicator outputs, one per condition, except that done also stays lit during transfer.
module tsc_capture
    import tsc_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 soft_rst_in,
    input  wire logic                 arm_in,
    input  wire logic                 triggered_indicator_src_ext_in,
    input  wire logic                 triggered_indicator_pol_rise_in,
    input  wire logic [SEL_W-1:0]     len_sel_in,
    input  wire logic                 xfer_start_in,
    input  wire logic                 usb_ready_in,
    input  wire logic                 conv_clk_in,
    input  wire logic                 ext_triggered_indicator_in,
    input  wire logic                 ovr_in,
    input  wire logic                 id_mem_present_in,
    input  wire logic                 id_mem_busy_in,
    input  wire logic                 power_good_in,
    input  wire logic [SMP_W-1:0]     smp_data_in,
    input  wire logic [SMP_W-1:0]     mem_rdata_in,
    output var tsc_pkg::tsc_mem_type  mem_out,
    output logic      [BYTE_W-1:0]    usb_data_out,
    output logic                      usb_wr_out,
    output var tsc_pkg::tsc_led_type  status_out
);
    import tsc_pkg::*;

    logic [PIN_W-1:0] pin_s;
    logic             conv_s;
    logic             triggered_indicator_s;
    logic             ovr_s;
    logic             idm_s;
    logic             pwr_s;
    logic [SMP_W-1:0] smp_s;

    // Samples are held for a whole conversion period, so the synchronised
    // bus is settled when the conversion edge is seen.
    tsc_sync #(.W(PIN_W)) u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .din_in   ({conv_clk_in, ext_triggered_indicator_in, ovr_in,
                    id_mem_present_in | id_mem_busy_in, power_good_in,
                    1'b0, smp_data_in}),
        .dout_out (pin_s)
    );
    assign conv_s = pin_s[PIN_W-1];
    assign triggered_indicator_s = pin_s[PIN_W-2];
    assign ovr_s  = pin_s[PIN_W-3];
    assign idm_s  = pin_s[PIN_W-4];
    assign pwr_s  = pin_s[PIN_W-5];
    assign smp_s  = pin_s[SMP_W-1:0];

    tsc_state_type     state_ff, nxt_state;
    logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
    logic [CNT_W-1:0]  len_ff, nxt_len;
    logic [SMP_W-1:0]  word_ff, nxt_word;
    logic              ovf_ff, nxt_ovf;
    logic              conv_d_ff, triggered_indicator_d_ff;
    tsc_mem_type       mem_ff, nxt_mem;
    logic [BYTE_W-1:0] usb_data_ff, nxt_usb_data;
    logic              usb_wr_ff, nxt_usb_wr;
    tsc_led_type       status_ff, nxt_status;
    logic              conv_rise;
    logic              ext_edge;
    logic              triggered_indicator_hit;
    logic [SEL_W-1:0]  sel_c;

    assign conv_rise = conv_s & ~conv_d_ff;
    assign ext_edge  = triggered_indicator_pol_rise_in ? (triggered_indicator_s & ~triggered_indicator_d_ff)
                                        : (~triggered_indicator_s & triggered_indicator_d_ff);
    assign triggered_indicator_hit  = triggered_indicator_src_ext_in ? ext_edge : conv_rise;

    always_comb
    begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_len      = len_ff;
        nxt_word     = word_ff;
        nxt_ovf      = ovf_ff;
        nxt_mem      = mem_ff;
        nxt_mem.we   = 1'b0;
        nxt_usb_data = usb_data_ff;
        nxt_usb_wr   = 1'b0;
        sel_c        = len_sel_in;
        case (state_ff)
            ST_IDLE, ST_DONE:
            begin
                if (arm_in)
                begin
                    nxt_len   = CNT_ONE << (LEN_BASE_LOG + 5'(sel_c));
                    nxt_cnt   = CNT_ZERO;
                    nxt_ovf   = 1'b0;
                    nxt_state = ST_ARMED;
                end
                else if (state_ff == ST_DONE && xfer_start_in)
                begin
                    nxt_cnt   = CNT_ZERO;
                    nxt_state = ST_XFER_RD;
                end
            end
            ST_ARMED:
                if (triggered_indicator_hit)
                    nxt_state = ST_CAPTURE;
            ST_CAPTURE:
            begin
                if (ovr_s)
                    nxt_ovf = 1'b1;
                if (conv_rise)
                begin
                    nxt_mem.we   = 1'b1;
                    nxt_mem.addr = cnt_ff[ADDR_W-1:0];
                    nxt_mem.data = smp_s;
                    nxt_cnt      = cnt_ff + CNT_ONE;
                    if (cnt_ff + CNT_ONE == len_ff)
                        nxt_state = ST_DONE;
                end
            end
            ST_XFER_RD:
            begin
                nxt_mem.addr = cnt_ff[ADDR_W-1:0];
                nxt_state    = ST_XFER_WAIT;
            end
            ST_XFER_WAIT:
            begin
                nxt_word  = mem_rdata_in;
                nxt_state = ST_XFER_LO;
            end
            ST_XFER_LO:
                if (usb_ready_in)
                begin
                    nxt_usb_data = word_ff[BYTE_W-1:0];
                    nxt_usb_wr   = 1'b1;
                    nxt_state    = ST_XFER_HI;
                end
            ST_XFER_HI:
                if (usb_ready_in && !usb_wr_ff)
                begin
                    nxt_usb_data = word_ff[SMP_W-1:BYTE_W];
                    nxt_usb_wr   = 1'b1;
                    nxt_cnt      = cnt_ff + CNT_ONE;
                    nxt_state    = (cnt_ff + CNT_ONE == len_ff) ? ST_DONE
                                                                : ST_XFER_RD;
                end
            default:
                nxt_state = ST_IDLE;
        endcase
        if (soft_rst_in)
        begin
            nxt_state = ST_IDLE;
            nxt_ovf   = 1'b0;
            nxt_mem   = MEM_IDLE;
            nxt_usb_wr = 1'b0;
        end
        nxt_status.transfer  = nxt_state inside {ST_XFER_RD, ST_XFER_WAIT,
                                   ST_XFER_LO, ST_XFER_HI};
        nxt_status.id_mem    = idm_s;
        nxt_status.reset     = soft_rst_in;
        nxt_status.power     = pwr_s;
        nxt_status.overflow  = nxt_ovf;
        nxt_status.done      = nxt_state == ST_DONE
                               || nxt_status.transfer;
        nxt_status.armed     = nxt_state == ST_ARMED;
        nxt_status.triggered = nxt_state == ST_CAPTURE;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_ff    <= ST_IDLE;
            cnt_ff      <= CNT_ZERO;
            len_ff      <= CNT_ZERO;
            word_ff     <= '0;
            ovf_ff      <= 1'b0;
            conv_d_ff   <= 1'b0;
            triggered_indicator_d_ff   <= 1'b0;
            mem_ff      <= MEM_IDLE;
            usb_data_ff <= '0;
            usb_wr_ff   <= 1'b0;
            status_ff   <= LED_RESET;
        end
        else
        begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            len_ff      <= nxt_len;
            word_ff     <= nxt_word;
            ovf_ff      <= nxt_ovf;
            conv_d_ff   <= conv_s;
            triggered_indicator_d_ff   <= triggered_indicator_s;
            mem_ff      <= nxt_mem;
            usb_data_ff <= nxt_usb_data;
            usb_wr_ff   <= nxt_usb_wr;
            status_ff   <= nxt_status;
        end
    end

    assign mem_out      = mem_ff;
    assign usb_data_out = usb_data_ff;
    assign usb_wr_out   = usb_wr_ff;
    assign status_out   = status_ff;

    // Checking logic
    logic [ADDR_W-1:0] last_addr_ff;
    logic              wrote_ff;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            last_addr_ff <= '0;
            wrote_ff     <= 1'b0;
        end
        else
        begin
            if (mem_ff.we)
                last_addr_ff <= mem_ff.addr;
            wrote_ff <= (state_ff == ST_CAPTURE) && (wrote_ff || mem_ff.we);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_low_byte;
        usb_wr_ff && state_ff == ST_XFER_HI;
    endsequence

    sequence s_high_byte;
        usb_wr_ff && state_ff != ST_XFER_HI;
    endsequence

    a_len_bound: assert property (
        mem_ff.we |-> CNT_W'(mem_ff.addr) < len_ff)
        else $error("write beyond selected block length");
    a_int_trigger: assert property (
        state_ff == ST_ARMED && !triggered_indicator_src_ext_in && conv_rise
        && !soft_rst_in |=> state_ff == ST_CAPTURE)
        else $error("internal trigger not accepted");
    a_ext_polarity: assert property (
        state_ff == ST_ARMED && triggered_indicator_src_ext_in && !ext_edge
        |=> state_ff != ST_CAPTURE)
        else $error("capture began without selected trigger edge");
    a_armed_led: assert property (
        state_ff == ST_ARMED |-> status_ff.armed && !status_ff.triggered)
        else $error("armed indicator wrong while waiting");
    a_triggered_indicator_led: assert property (
        $rose(status_ff.triggered) |-> $past(state_ff) == ST_ARMED)
        else $error("triggered indicator without trigger");
    a_done_count: assert property (
        $rose(status_ff.done) |-> mem_ff.we
        && CNT_W'(mem_ff.addr) == len_ff - CNT_ONE)
        else $error("done before last sample stored");
    // A soft reset or re-arm in the following cycle may clear it legally
    a_ovf_sticky: assert property (
        (state_ff == ST_CAPTURE && ovr_s && !soft_rst_in)
        ##1 (!soft_rst_in && !arm_in)
        |-> status_ff.overflow ##1 status_ff.overflow)
        else $error("overflow not held");
    a_reset_led: assert property (
        soft_rst_in |=> status_ff.reset ##1 (status_ff.reset == $past(soft_rst_in)))
        else $error("reset indicator not following soft reset");
    a_xfer_led: assert property (
        usb_wr_ff |-> status_ff.transfer || status_ff.done)
        else $error("byte sent without transfer state");
    a_store_step: assert property (
        mem_ff.we && wrote_ff |-> mem_ff.addr == last_addr_ff + 1'b1)
        else $error("write address did not step by one");
    a_soft_clear: assert property (
        soft_rst_in |=> state_ff == ST_IDLE && !status_ff.armed
        && !status_ff.triggered && !status_ff.done && !status_ff.overflow)
        else $error("soft reset did not clear capture state");
    a_byte_pair: assert property (
        s_low_byte |-> ##[1:300] s_high_byte or (soft_rst_in or !usb_ready_in))
        else $error("high byte did not follow low byte");

endmodule : tsc_capture

`default_nettype wire

// [tb/tsc_conv_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Converter board: free running conversion clock, counting sample words
module tsc_conv_model
    import tsc_pkg::*;
(
    input  wire logic                    ovr_req_in,
    output logic                         conv_clk_out,
    output logic [tsc_pkg::SMP_W-1:0]    smp_data_out,
    output logic                         ovr_out
);
    import tsc_pkg::*;

    // New word on the falling edge, half a period ahead of the rising edge
    initial
    begin
        conv_clk_out = 1'b0;
        smp_data_out = 16'h0000;
        #37;
        forever
        begin
            #200 conv_clk_out = 1'b1;
            #200 conv_clk_out = 1'b0;
            smp_data_out = smp_data_out + 16'h0001;
        end
    end

    assign ovr_out = ovr_req_in;
endmodule : tsc_conv_model

`default_nettype wire

// [tb/triggered_sample_capture_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module triggered_sample_capture_tb;
    import tsc_pkg::*;

    // Row fields: ext, pol, sel[2:0], ovr, xfer
    typedef struct packed {
        logic       ext;
        logic       pol;
        logic [2:0] sel;
        logic       ovr;
        logic       xfer;
    } tsc_row_type;
    localparam tsc_row_type ROWS [3] = '{7'h03, 7'h60, 7'h44};

    logic clk_in, rst_n_in, soft_rst_in, arm_in, ovr_req;
    logic triggered_indicator_src_ext_in, triggered_indicator_pol_rise_in, xfer_start_in, usb_ready_in;
    logic ext_triggered_indicator_in, id_mem_present_in, id_mem_busy_in, power_good_in;
    logic [2:0]  len_sel_in;
    logic [15:0] mem_rdata_in, first, last;
    logic [7:0]  usb_data_out;
    logic        usb_wr_out;
    wire logic   conv_clk, ovr_pin;
    wire logic [15:0] smp;
    tsc_mem_type mem_out;
    tsc_led_type status_out;
    int n_fail, checks, wcnt;
    logic [15:0] ram [0:131071];
    logic [7:0]  bq [$];

    tsc_conv_model conv_u (.ovr_req_in(ovr_req), .conv_clk_out(conv_clk),
        .smp_data_out(smp), .ovr_out(ovr_pin));
    tsc_capture dut_u (.clk_in, .rst_n_in, .soft_rst_in, .arm_in,
        .triggered_indicator_src_ext_in, .triggered_indicator_pol_rise_in, .len_sel_in, .xfer_start_in,
        .usb_ready_in, .conv_clk_in(conv_clk), .ext_triggered_indicator_in,
        .ovr_in(ovr_pin), .id_mem_present_in, .id_mem_busy_in,
        .power_good_in, .smp_data_in(smp), .mem_rdata_in, .mem_out,
        .usb_data_out, .usb_wr_out, .status_out);

    always #25 clk_in = ~clk_in;

    // Sample memory: writes land on the clock; read data follows the
    // registered address, so the word is ready in the design's wait state
    always @(posedge clk_in)
    begin
        if (mem_out.we) ram[mem_out.addr] <= mem_out.data;
    end

    assign mem_rdata_in = ram[mem_out.addr];

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    always @(negedge clk_in)
    begin
        if (mem_out.we)
        begin
            chk(mem_out.addr, wcnt);
            if (wcnt != 0) chk(mem_out.data, last + 16'h0001);
            if (wcnt == 0) first = mem_out.data;
            last = mem_out.data;
            wcnt++;
        end
        if (usb_wr_out) bq.push_back(usb_data_out);
    end

    task automatic wait_led(input int b, input logic v, input int lim);
        int i;
        i = 0;
        while (status_out[b] !== v && i < lim)
        begin
            @(negedge clk_in);
            i++;
        end
        chk(status_out[b], v);
    endtask : wait_led

    task automatic xfer(input int n);
        int i;
        bq = {};
        xfer_start_in = 1'b1;
        @(negedge clk_in);
        xfer_start_in = 1'b0;
        chk(status_out.transfer, 1'b1);
        for (i = 0; status_out.transfer === 1'b1 && i < n * 16; i++)
        begin
            usb_ready_in = i[1];
            @(negedge clk_in);
        end
        usb_ready_in = 1'b1;
        @(negedge clk_in);
        chk(bq.size(), 2 * n);
        for (i = 0; i < n; i++)
            chk({bq[2*i+1], bq[2*i]}, first + i[15:0]);
    endtask : xfer

    task automatic run_row(input tsc_row_type r);
        int n;
        n = 1 << (10 + r.sel);
        triggered_indicator_src_ext_in = r.ext;
        triggered_indicator_pol_rise_in = r.pol;
        len_sel_in = r.sel;
        ext_triggered_indicator_in = r.pol;
        ovr_req = r.ovr;
        repeat (6) @(negedge clk_in);
        wcnt = 0;
        arm_in = 1'b1;
        @(negedge clk_in);
        arm_in = 1'b0;
        chk(status_out.armed, 1'b1);
        chk(status_out.overflow, 1'b0);
        if (r.ext)
        begin
            ext_triggered_indicator_in = ~r.pol;
            repeat (20) @(negedge clk_in);
            chk(status_out[1:0], 2'h2);
            ext_triggered_indicator_in = r.pol;
        end
        wait_led(0, 1'b1, 20);
        chk(status_out.armed, 1'b0);
        wait_led(2, 1'b1, n * 9);
        @(negedge clk_in);
        chk(status_out.triggered, 1'b0);
        chk(wcnt, n);
        chk(status_out.overflow, r.ovr);
        if (r.xfer) xfer(n);
    endtask : run_row

    task automatic wrap_up();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial
    begin
        #5000000;
        n_fail++;
        wrap_up();
    end

    initial
    begin
        {clk_in, rst_n_in, soft_rst_in, arm_in, ovr_req} = 5'h00;
        {triggered_indicator_src_ext_in, triggered_indicator_pol_rise_in, xfer_start_in} = 3'h0;
        {ext_triggered_indicator_in, id_mem_present_in, id_mem_busy_in} = 3'h0;
        usb_ready_in = 1'b1;
        power_good_in = 1'b1;
        len_sel_in = 3'h0;
        {n_fail, checks, wcnt} = '0;
        repeat (16) @(negedge clk_in);
        chk(status_out, LED_RESET);
        rst_n_in = 1'b1;
        wait_led(4, 1'b1, 5);
        chk(status_out.reset, 1'b0);
        foreach (ROWS[k]) run_row(ROWS[k]);
        id_mem_present_in = 1'b1;
        wait_led(6, 1'b1, 5);
        {id_mem_present_in, id_mem_busy_in} = 2'h1;
        repeat (5) @(negedge clk_in);
        chk(status_out.id_mem, 1'b1);
        {id_mem_busy_in, power_good_in} = 2'h0;
        wait_led(6, 1'b0, 5);
        wait_led(4, 1'b0, 5);
        // Soft reset in mid-capture with overflow and triggered both lit
        triggered_indicator_src_ext_in = 1'b0;
        ovr_req = 1'b1;
        wcnt = 0;
        arm_in = 1'b1;
        @(negedge clk_in);
        arm_in = 1'b0;
        wait_led(0, 1'b1, 20);
        repeat (20) @(negedge clk_in);
        chk(status_out[3:0], 4'h9);
        soft_rst_in = 1'b1;
        @(negedge clk_in);
        chk(status_out[5], 1'b1);
        chk(status_out[3:0], 4'h0);
        soft_rst_in = 1'b0;
        ovr_req = 1'b0;
        @(negedge clk_in);
        chk(status_out[5], 1'b0);
        repeat (20) @(negedge clk_in);
        chk(status_out[3:0], 4'h0);
        wrap_up();
    end
endmodule : triggered_sample_capture_tb

`default_nettype wire
